// File: logic/lock_detect_defines.vh
// Constants for the PLL digital lock detect block.
`ifndef LOCK_DETECT_DEFINES_VH
`define LOCK_DETECT_DEFINES_VH
// Lock detect count field and window bit of configuration register 0x018.
`define LD_CFG_COUNT_REG 12'h018
`define LD_COUNT_MSB 6
`define LD_COUNT_LSB 5
`define LD_WINDOW_BIT 4
// Antibacklash field of register 0x017.
`define LD_ABP_REG 12'h017
`define LD_ABP_MSB 1
`define LD_ABP_LSB 0
// Consecutive good cycles needed for each count code.
`define LD_COUNT_C0 8'h05
`define LD_COUNT_C1 8'h10
`define LD_COUNT_C2 8'h40
`define LD_COUNT_C3 8'hFF
// Base lock window in ref_clk cycles; unlock window is wider.
`define LD_LOCK_BASE 8'h02
`define LD_UNLOCK_EXTRA 8'h02
// Delay cell range in ps and steps.
`define LD_DELAY_RANGE_PS 1000
`define LD_DELAY_STEPS 8
// Output mux selector codes.
`define LD_MUX_LOW 2'h0
`define LD_MUX_LOCK 2'h1
`define LD_MUX_HIGH 2'h2
`define LD_MUX_NLOCK 2'h3
// Prescaler mode codes.
`define PS_MODE_FD 1'b0
`define PS_MODE_DM 1'b1
`endif

// File: logic/pll_digital_lock_detect.v
// PLL digital lock detect with divider delay taps and output pin muxes.
`timescale 1ns/1ns
`default_nettype none
`include "lock_detect_defines.vh"
module pll_digital_lock_detect (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Detector edge events (one-cycle pulses) and power-down
  input wire ref_edge,
  input wire fb_edge,
  input wire pll_power_down,
  // Configuration
  input wire [1:0] lock_count_sel,
  input wire lock_window_sel,
  input wire [1:0] antibacklash_sel,
  input wire [2:0] ref_delay_sel,
  input wire ref_delay_en,
  input wire [2:0] fb_delay_sel,
  input wire fb_delay_en,
  input wire [1:0] ld_pin_sel,
  input wire [1:0] status_pin_sel,
  input wire [1:0] monitor_pin_sel,
  // Feedback divider settings
  input wire dual_modulus_mode,
  input wire [5:0] prescaler_p,
  input wire [12:0] b_count,
  input wire [5:0] a_count,
  // Outputs
  output reg [2:0] ref_delay_tap,
  output reg [2:0] fb_delay_tap,
  output reg [18:0] feedback_ratio,
  output reg counters_bypassed,
  output reg digital_lock_indicator,
  output reg lock_detect_pin,
  output reg status_pin,
  output reg reference_monitor_pin
);

  function mux_pick;
    input [1:0] sel;
    input lock;
    begin
      case (sel)
        `LD_MUX_LOW: mux_pick = 1'b0;
        `LD_MUX_LOCK: mux_pick = lock;
        `LD_MUX_HIGH: mux_pick = 1'b1;
        default: mux_pick = ~lock;
      endcase
    end
  endfunction

  reg [7:0] gap_q;
  reg [7:0] gap_d;
  reg wait_q;
  reg wait_d;
  reg [7:0] good_q;
  reg [7:0] good_d;
  reg lock_d;
  reg [7:0] lock_win;
  reg [7:0] unlock_win;
  reg [7:0] need;
  reg both;
  reg [5:0] a_eff;
  wire pin_lock;
  wire [5:0] pin_sel_bus;
  wire [2:0] pin_d;
  genvar k;

  // Power-down forces every pin mux to see an unlocked loop, so a pin set
  // to show the inverted lock goes high at once rather than one cycle late.
  assign pin_lock = pll_power_down ? 1'b0 : lock_d;
  assign pin_sel_bus = {monitor_pin_sel, status_pin_sel, ld_pin_sel};

  // Each pin has its own selector; bit 0 is the lock detect pin, bit 1 the
  // status pin and bit 2 the reference monitor pin.
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_pin_mux
      assign pin_d[k] = mux_pick(pin_sel_bus[2*k+1:2*k], pin_lock);
    end
  endgenerate

  // Wider window bit and longer antibacklash both widen the windows.
  always @* begin
    lock_win = `LD_LOCK_BASE + {6'h00, antibacklash_sel}
      + {7'h00, lock_window_sel};
    unlock_win = lock_win + `LD_UNLOCK_EXTRA;
    case (lock_count_sel)
      2'h0: need = `LD_COUNT_C0;
      2'h1: need = `LD_COUNT_C1;
      2'h2: need = `LD_COUNT_C2;
      default: need = `LD_COUNT_C3;
    endcase
  end

  // One edge opens a gap count; the other closes it. This relies on the
  // comparison period exceeding the unlock window so pairs never overlap.
  always @* begin
    gap_d = gap_q;
    wait_d = wait_q;
    good_d = good_q;
    lock_d = digital_lock_indicator;
    both = 1'b0;
    if (ref_edge && fb_edge) begin
      both = 1'b1;
      gap_d = 8'h00;
      wait_d = 1'b0;
    end else if (ref_edge || fb_edge) begin
      if (wait_q) begin
        both = 1'b1;
        wait_d = 1'b0;
      end else begin
        wait_d = 1'b1;
        gap_d = 8'h00;
      end
    end else if (wait_q && gap_q != 8'hFF) begin
      gap_d = gap_q + 8'h01;
    end
    if (wait_q && gap_q > unlock_win) begin
      wait_d = 1'b0;
      lock_d = 1'b0;
      good_d = 8'h00;
    end else if (both) begin
      if (wait_q && gap_q > unlock_win) begin
        lock_d = 1'b0;
      end else if (!wait_q || gap_q < lock_win) begin
        if (good_q != need) begin
          good_d = good_q + 8'h01;
        end
        if (good_q + 8'h01 >= need) begin
          lock_d = 1'b1;
        end
      end else begin
        good_d = 8'h00;
      end
      if (wait_q && gap_q > unlock_win) begin
        lock_d = 1'b0;
        good_d = 8'h00;
      end
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gap_q <= 8'h00;
      wait_q <= 1'b0;
      good_q <= 8'h00;
      digital_lock_indicator <= 1'b0;
      lock_detect_pin <= 1'b0;
      status_pin <= 1'b0;
      reference_monitor_pin <= 1'b0;
    end else if (pll_power_down) begin
      gap_q <= 8'h00;
      wait_q <= 1'b0;
      good_q <= 8'h00;
      digital_lock_indicator <= 1'b0;
      lock_detect_pin <= pin_d[0];
      status_pin <= pin_d[1];
      reference_monitor_pin <= pin_d[2];
    end else begin
      gap_q <= gap_d;
      wait_q <= wait_d;
      good_q <= good_d;
      digital_lock_indicator <= lock_d;
      // The pins are loaded from the same next value as the indicator, so
      // they never lag it by a cycle.
      lock_detect_pin <= pin_d[0];
      status_pin <= pin_d[1];
      reference_monitor_pin <= pin_d[2];
    end
  end

  // Fixed divide mode forces the swallow count to zero.
  // The ratio is only reported here; the dividers themselves live elsewhere,
  // so a setting that the dividers cannot run is not refused by this block.
  always @* begin
    a_eff = (dual_modulus_mode == `PS_MODE_DM) ? a_count : 6'h00;
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_delay_tap <= 3'h0;
      fb_delay_tap <= 3'h0;
      feedback_ratio <= 19'h0_0000;
      counters_bypassed <= 1'b0;
    end else begin
      // Disabled cells sit at tap zero; eight taps span about 1 ns.
      ref_delay_tap <= ref_delay_en ? ref_delay_sel : 3'h0;
      fb_delay_tap <= fb_delay_en ? fb_delay_sel : 3'h0;
      counters_bypassed <= (b_count == 13'h0001);
      if (b_count == 13'h0001) begin
        feedback_ratio <= {13'h0000, prescaler_p};
      end else begin
        feedback_ratio <= prescaler_p * b_count + {13'h0000, a_eff};
      end
    end
  end

endmodule // pll_digital_lock_detect
`default_nettype wire

// File: test/lock_detect_props.sv
// Assertions on the ports of the PLL digital lock detect block.
`timescale 1ns/1ns
`default_nettype none
module lock_detect_props (
  // Clock, reset and control
  input wire ref_clk,
  input wire rstn,
  input wire pll_power_down,
  // Settings
  input wire ref_delay_en,
  input wire [2:0] ref_delay_sel,
  input wire dual_modulus_mode,
  input wire [5:0] prescaler_p,
  input wire [12:0] b_count,
  input wire [5:0] a_count,
  input wire [1:0] ld_pin_sel,
  input wire [1:0] status_pin_sel,
  input wire [1:0] monitor_pin_sel,
  // Outputs
  input wire [2:0] ref_delay_tap,
  input wire [18:0] feedback_ratio,
  input wire counters_bypassed,
  input wire digital_lock_indicator,
  input wire lock_detect_pin,
  input wire status_pin,
  input wire reference_monitor_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // A rise may only follow an edge at which power-down was low.
  sequence s_lock_set; $rose(digital_lock_indicator); endsequence
  property p_tap; $past(rstn) |-> ref_delay_tap == ($past(ref_delay_en) ? $past(ref_delay_sel) : 3'h0); endproperty
  a_tap: assert property (p_tap) else $error("delay tap wrong");
  property p_ratio; $past(rstn) && $past(b_count) != 13'h1 |-> feedback_ratio == $past(19'(prescaler_p) * b_count + (dual_modulus_mode ? a_count : 6'h0)); endproperty
  a_ratio: assert property (p_ratio) else $error("ratio wrong");
  property p_bypass; $past(rstn) && $past(b_count) == 13'h1 |-> counters_bypassed && feedback_ratio == 19'($past(prescaler_p)); endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  property p_ld; $past(rstn) && ld_pin_sel == 2'h1 && $stable(ld_pin_sel) |-> lock_detect_pin == digital_lock_indicator; endproperty
  a_ld: assert property (p_ld) else $error("lock pin wrong");
  property p_mon; $past(rstn) && monitor_pin_sel == 2'h3 && $stable(monitor_pin_sel) |-> reference_monitor_pin != digital_lock_indicator; endproperty
  a_mon: assert property (p_mon) else $error("monitor pin wrong");
  property p_stat; $past(rstn) && status_pin_sel == 2'h2 && $stable(status_pin_sel) |-> status_pin; endproperty
  a_stat: assert property (p_stat) else $error("status pin wrong");
  property p_pd; pll_power_down |=> !digital_lock_indicator; endproperty
  a_pd: assert property (p_pd) else $error("lock kept in power down");
  property p_rise; s_lock_set |-> !$past(pll_power_down); endproperty
  a_rise: assert property (p_rise) else $error("lock rose in power down");
endmodule // lock_detect_props
bind pll_digital_lock_detect lock_detect_props u_props (.*);
`default_nettype wire

// File: test/tb_pll_digital_lock_detect.sv
// Testbench for the PLL digital lock detect block.
`timescale 1ns/1ns
`default_nettype none
module tb_pll_digital_lock_detect;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg ref_edge = 1'b0, fb_edge = 1'b0, pll_power_down = 1'b0, lock_window_sel = 1'b0;
  // Dual modulus runs with a prescaler of 8, never the 2/3 mode.
  reg ref_delay_en = 1'b1, fb_delay_en = 1'b0, dual_modulus_mode = 1'b1;
  reg [1:0] lock_count_sel = 2'h0, antibacklash_sel = 2'h0, ld_pin_sel = 2'h1;
  reg [1:0] status_pin_sel = 2'h2, monitor_pin_sel = 2'h3;
  reg [2:0] ref_delay_sel = 3'h5, fb_delay_sel = 3'h3;
  reg [5:0] prescaler_p = 6'h08, a_count = 6'h06;
  reg [12:0] b_count = 13'h0012;
  wire [2:0] ref_delay_tap, fb_delay_tap;
  wire [18:0] feedback_ratio;
  wire counters_bypassed, digital_lock_indicator, lock_detect_pin, status_pin;
  wire reference_monitor_pin;
  integer bad_count = 0;
  integer checked = 0;
  integer s, i;
  always #20 ref_clk = ~ref_clk;
  pll_digital_lock_detect u_dut (.*);
  task chk(input [18:0] got, input [18:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task final_report;
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  // One comparison pair with the given gap, then idle well past the unlock window.
  task pair(input integer g);
    ref_edge = 1'b1;
    fb_edge = (g == 0);
    tick(1);
    ref_edge = 1'b0;
    fb_edge = 1'b0;
    if (g > 0) begin
      tick(g - 1);
      fb_edge = 1'b1;
      tick(1);
      fb_edge = 1'b0;
    end
    tick(12);
  endtask
  task clr;
    pll_power_down = 1'b1;
    tick(1);
    pll_power_down = 1'b0;
    tick(2);
  endtask
  initial begin
    #2000000;
    bad_count++;
    final_report;
  end
  initial begin
    tick(16);
    rstn = 1'b1;
    tick(2);
    chk(ref_delay_tap, 19'h0_0005);
    chk(fb_delay_tap, 19'h0_0000);
    fb_delay_en = 1'b1;
    tick(2);
    chk(fb_delay_tap, 19'h0_0003);
    chk(feedback_ratio, 19'h0_0096);
    dual_modulus_mode = 1'b0;
    tick(2);
    chk(feedback_ratio, 19'h0_0090);
    b_count = 13'h0001;
    prescaler_p = 6'h02;
    tick(2);
    chk(feedback_ratio, 19'h0_0002);
    chk(counters_bypassed, 19'h0_0001);
    for (s = 0; s < 4; s++) begin
      lock_count_sel = s;
      clr;
      chk(digital_lock_indicator, 19'h0_0000);
      for (i = 1; i < (s == 0 ? 5 : s == 1 ? 16 : s == 2 ? 64 : 255); i++) pair(1);
      chk(digital_lock_indicator, 19'h0_0000);
      pair(0);
      chk(digital_lock_indicator, 19'h0_0001);
      chk(lock_detect_pin, 19'h0_0001);
      chk(status_pin, 19'h0_0001);
      chk(reference_monitor_pin, 19'h0_0000);
    end
    pair(3);
    chk(digital_lock_indicator, 19'h0_0001);
    pair(6);
    chk(digital_lock_indicator, 19'h0_0000);
    antibacklash_sel = 2'h3;
    lock_window_sel = 1'b1;
    lock_count_sel = 2'h0;
    repeat (5) pair(5);
    chk(digital_lock_indicator, 19'h0_0001);
    // Selector code 0 forces the lock detect pin low, whatever the indicator shows.
    ld_pin_sel = 2'h0;
    tick(2);
    chk(lock_detect_pin, 19'h0_0000);
    final_report;
  end
endmodule // tb_pll_digital_lock_detect
`default_nettype wire
